//--- hw/timer8.sv
// eight-bit timer/counter with shared prescaler behind an ahb-lite slave
// How it works
// [RL1] source clear: count every instruction cycle
// [RL2] counter write holds off two increments
// [RL3] source set: count external input edges
// [RL4] edge bit: clear rising, set falling
// [RL5] assignment bit: clear timer, set watchdog
// [RL6] rate field divides 1:2 to 1:256
// [RL7] prescaler count has no software access
// [RL8] wrap from ff to 00 sets flag
// [RL9] enable bit clear masks overflow request
// [RL10] software clears flag before re-enabling
// [RL11] timer stopped during sleep
// [RL12] prescaler output sampled second, fourth phase
// [RL13] input high and low two periods
// [RL14] ripple divide; input period limit applies
// [RL15] one prescaler, timer or watchdog only
// [RL16] counter write clears timer-assigned prescaler
// [RL17] clear-watchdog clears watchdog-assigned prescaler
// [RL18] assignment may change at any time
// [RL19] timer to watchdog switch sequence
// [RL20] watchdog to timer switch sequence
// [RL21] two-stage sampler, one increment per edge
//
// Chosen here: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
module timer8
   import tmr_pkg::*;
#(
   parameter int PRESC_WIDTH = 8
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic external_count_input,
   input wire logic wdt_tick,
   output logic irq,
   output logic wdt_clear,
   output logic wdt_postscaled
);
   // software visible state
   logic [7:0] counter_register; // the timer value
   logic [7:0] option_register; // source, edge, assignment, rate
   logic overflow_flag; // sticky overflow
   logic overflow_irq_enable; // overflow request mask
   logic sleep_mode; // timer stopped while set
   // bus address phase capture
   logic ap_valid; // a data phase is pending
   logic ap_write; // pending phase is a write
   logic [3:0] ap_addr; // low address bits of pending phase
   // timing state
   logic [1:0] phase; // phase clock index within instruction cycle
   logic [1:0] inhibit; // instruction cycles left without increment
   logic ext_prev; // previous selected-polarity input level
   logic sync1; // first sampler stage, at second phase
   logic sync2; // second sampler stage, at fourth phase
   logic sync3; // history of second stage for edge detect
   logic [PRESC_WIDTH-1:0] presc_count; // prescaler value
   // derived strobes
   logic q2, q4, ext_sel, ext_edge, wr_counter, wr_option, wr_intctl, wr_control;
   logic clrwd_cmd, presc_tick, presc_clear, pre_level, inc_event, count_enable;
   logic clock_source_select, source_edge_select, prescaler_assignment;
   logic [2:0] prescale_rate_field;
   logic [7:0] next_counter;
   logic [7:0] wdt_mask;

   // address decode used by every register strobe
   function automatic logic reg_hit(input logic [3:0] addr, input logic [3:0] off);
      reg_hit = (addr == off);
   endfunction

   // option fields
   assign clock_source_select = option_register[POS_SOURCE];
   assign source_edge_select = option_register[POS_EDGE];
   assign prescaler_assignment = option_register[POS_ASSIGN];
   assign prescale_rate_field = option_register[POS_RATE_LO +: 3];

   // bus answers: zero wait states, always okay
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // address phase capture on a valid nonseq word transfer
   always_ff @(posedge clk) begin
      if (!nrst) begin
         ap_valid <= 1'b0;
         ap_write <= 1'b0;
         ap_addr <= 4'h0;
      end else if (hready) begin
         ap_valid <= hsel && (htrans == HTRANS_NONSEQ) && (hsize == 3'h2);
         ap_write <= hwrite;
         ap_addr <= haddr[3:0];
      end
   end

   // read data prepared at the address phase, held in a flop
   always_ff @(posedge clk) begin
      if (!nrst) begin
         hrdata <= 32'h0;
      end else if (hready && hsel && !hwrite && (htrans == HTRANS_NONSEQ)) begin
         // prescaler count is never placed on the bus
         // [RL7] no prescaler read
         unique case (haddr[3:0])
            OFF_COUNTER: hrdata <= {24'h0, counter_register};
            OFF_OPTION: hrdata <= {24'h0, option_register};
            OFF_INTCTL: hrdata <= {26'h0, overflow_irq_enable, 2'h0, overflow_flag, 2'h0};
            OFF_CONTROL: hrdata <= {31'h0, sleep_mode};
            default: hrdata <= 32'h0;
         endcase
      end
   end

   // data phase write strobes; unmapped writes are dropped
   assign wr_counter = ap_valid && ap_write && reg_hit(ap_addr, OFF_COUNTER);
   assign wr_option = ap_valid && ap_write && reg_hit(ap_addr, OFF_OPTION);
   assign wr_intctl = ap_valid && ap_write && reg_hit(ap_addr, OFF_INTCTL);
   assign wr_control = ap_valid && ap_write && reg_hit(ap_addr, OFF_CONTROL);
   assign clrwd_cmd = wr_control && hwdata[POS_CLRWD];

   // option register, writable at any moment
   always_ff @(posedge clk) begin
      if (!nrst) begin
         option_register <= RST_OPTION;
      end else if (wr_option) begin
         // [RL18] live reassignment
         option_register <= hwdata[7:0];
      end
   end

   // sleep control bit
   always_ff @(posedge clk) begin
      if (!nrst) begin
         sleep_mode <= 1'b0;
      end else if (wr_control) begin
         sleep_mode <= hwdata[POS_SLEEP];
      end
   end

   // phase clock divider: one instruction cycle is four clocks
   always_ff @(posedge clk) begin
      if (!nrst) begin
         phase <= 2'h0;
      end else begin
         phase <= phase + 2'h1;
      end
   end
   assign q2 = (phase == PH_SECOND);
   assign q4 = (phase == PH_FOURTH);

   // edge choice on the count input
   // [RL4] polarity select
   assign ext_sel = external_count_input ^ source_edge_select;
   always_ff @(posedge clk) begin
      if (!nrst) begin
         // start from the pin's own level so release gives no false edge
         ext_prev <= ext_sel;
      end else begin
         ext_prev <= ext_sel;
      end
   end
   assign ext_edge = ext_sel && !ext_prev;

   // prescaler feed: timer source or watchdog ticks, never both
   // [RL15] single shared count
   // [RL5] assignment steering
   // [RL14] input edges divided ahead of sync
   assign presc_tick = prescaler_assignment ? wdt_tick :
      (!sleep_mode && (clock_source_select ? ext_edge : q4));
   // [RL16] counter write clears timer prescaler
   // [RL17] clear-watchdog clears watchdog prescaler
   assign presc_clear = prescaler_assignment ? clrwd_cmd : wr_counter;

   shared_prescaler #(
      .WIDTH(PRESC_WIDTH)
   ) shared_prescaler_i (
      .clk(clk),
      .nrst(nrst),
      .tick(presc_tick),
      .clear(presc_clear),
      .count(presc_count)
   );

   // prescaler output: bit n rises once every 2^(n+1) ticks
   // [RL6] ratio select
   assign pre_level = prescaler_assignment ? ext_sel : presc_count[prescale_rate_field];

   // sampler: first stage at second phase, second at fourth
   // [RL12] phase sampling
   always_ff @(posedge clk) begin
      if (!nrst) begin
         // preload the idle level: a rise seen after reset would count
         sync1 <= pre_level;
      end else if (q2) begin
         sync1 <= pre_level;
      end
   end
   // [RL21] two-stage sampler
   always_ff @(posedge clk) begin
      if (!nrst) begin
         sync2 <= pre_level;
         sync3 <= pre_level;
      end else if (q4) begin
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   // increment events land only on the fourth phase
   // [RL1] timer mode direct
   // [RL3] counter mode via sampler
   assign inc_event = q4 && ((!clock_source_select && prescaler_assignment) ||
      (sync2 && !sync3));
   // [RL11] stopped in sleep
   assign count_enable = !sleep_mode && (inhibit == 2'h0);

   // write hold-off counter in instruction cycles
   always_ff @(posedge clk) begin
      if (!nrst) begin
         inhibit <= 2'h0;
      end else if (wr_counter) begin
         // [RL2] two cycle hold
         inhibit <= INHIBIT_CYCLES;
      end else if (q4 && inhibit != 2'h0) begin
         inhibit <= inhibit - 2'h1;
      end
   end

   // counter register: write wins over increment
   assign next_counter = counter_register + 8'h01;
   always_ff @(posedge clk) begin
      if (!nrst) begin
         counter_register <= RST_COUNTER;
      end else if (wr_counter) begin
         counter_register <= hwdata[7:0];
      end else if (inc_event && count_enable) begin
         counter_register <= next_counter;
      end
   end

   // overflow flag: set beats a software clear in the same cycle
   always_ff @(posedge clk) begin
      if (!nrst) begin
         overflow_flag <= 1'b0;
         overflow_irq_enable <= 1'b0;
      end else begin
         if (wr_intctl) begin
            overflow_irq_enable <= hwdata[POS_IRQ_EN];
         end
         // [RL8] wrap sets flag
         if (!wr_counter && inc_event && count_enable && counter_register == 8'hff) begin
            overflow_flag <= 1'b1;
         end else if (wr_intctl) begin
            // [RL10] cleared only by software
            overflow_flag <= hwdata[POS_FLAG];
         end
      end
   end

   // [RL9] masked request
   assign irq = overflow_flag && overflow_irq_enable;

   // watchdog side: clear pulse and postscaled timeout
   assign wdt_mask = (8'h01 << prescale_rate_field) - 8'h01;
   always_ff @(posedge clk) begin
      if (!nrst) begin
         wdt_clear <= 1'b0;
         wdt_postscaled <= 1'b0;
      end else begin
         wdt_clear <= clrwd_cmd;
         wdt_postscaled <= prescaler_assignment && wdt_tick &&
            ((presc_count[7:0] & wdt_mask) == wdt_mask);
      end
   end

   // checks
   a_timer_mode_step: assert property (@(posedge clk) disable iff (!nrst) // [RL1]
      (!clock_source_select && prescaler_assignment && q4 && !sleep_mode && inhibit == 2'h0
       && !wr_counter) |=> counter_register == $past(counter_register) + 8'h01)
      else $error("timer mode missed an increment");
   a_write_inhibit: assert property (@(posedge clk) disable iff (!nrst) // [RL2]
      wr_counter |=> (counter_register == $past(hwdata[7:0])) && inhibit == 2'h2)
      else $error("counter write did not start hold-off");
   a_hold_stable: assert property (@(posedge clk) disable iff (!nrst) // [RL2]
      (inhibit != 2'h0 && !wr_counter) |=> counter_register == $past(counter_register))
      else $error("counter moved during hold-off");
   a_wrap_flag: assert property (@(posedge clk) disable iff (!nrst) // [RL8]
      ($past(counter_register) == 8'hff && counter_register == 8'h00 && !$past(wr_counter))
      |-> overflow_flag)
      else $error("wrap did not set overflow flag");
   a_irq_mask: assert property (@(posedge clk) disable iff (!nrst) // [RL9]
      !overflow_irq_enable |-> !irq)
      else $error("masked overflow raised a request");
   a_sleep_hold: assert property (@(posedge clk) disable iff (!nrst) // [RL11]
      (sleep_mode && !wr_counter) |=> counter_register == $past(counter_register))
      else $error("counter moved during sleep");
   a_presc_clear: assert property (@(posedge clk) disable iff (!nrst) // [RL16]
      (wr_counter && !prescaler_assignment) |=> presc_count == '0)
      else $error("counter write left prescaler uncleared");
   a_wd_clear: assert property (@(posedge clk) disable iff (!nrst) // [RL17]
      (clrwd_cmd && prescaler_assignment) |=> presc_count == '0 && wdt_clear)
      else $error("clear-watchdog left prescaler uncleared");
   a_fourth_phase: assert property (@(posedge clk) disable iff (!nrst) // [RL12]
      (counter_register != $past(counter_register) && !$past(wr_counter)) |-> $past(q4))
      else $error("increment off the fourth phase");
   a_one_step: assert property (@(posedge clk) disable iff (!nrst) // [RL21]
      !$past(wr_counter) |-> (counter_register == $past(counter_register) ||
      counter_register == $past(counter_register) + 8'h01))
      else $error("counter jumped more than one");
   a_no_sharing: assert property (@(posedge clk) disable iff (!nrst) // [RL15]
      wdt_postscaled |-> $past(prescaler_assignment))
      else $error("watchdog postscale while assigned to timer");
endmodule

//--- pkg/tmr_pkg.sv
// shared constants for the eight-bit timer with shared prescaler
package tmr_pkg;
   // register byte offsets on the bus
   localparam logic [3:0] OFF_COUNTER = 4'h0;
   localparam logic [3:0] OFF_OPTION = 4'h4;
   localparam logic [3:0] OFF_INTCTL = 4'h8;
   localparam logic [3:0] OFF_CONTROL = 4'hc;
   // option register field positions
   localparam int POS_RATE_LO = 0;
   localparam int POS_ASSIGN = 3;
   localparam int POS_EDGE = 4;
   localparam int POS_SOURCE = 5;
   // interrupt control field positions
   localparam int POS_FLAG = 2;
   localparam int POS_IRQ_EN = 5;
   // control register field positions
   localparam int POS_SLEEP = 0;
   localparam int POS_CLRWD = 1;
   // reset values
   localparam logic [7:0] RST_OPTION = 8'hff;
   localparam logic [7:0] RST_COUNTER = 8'h00;
   // phase clocks per instruction cycle, and phase indices
   localparam int PHASES = 4;
   localparam logic [1:0] PH_SECOND = 2'h1;
   localparam logic [1:0] PH_FOURTH = 2'h3;
   // increments held off after a counter write, in instruction cycles
   localparam logic [1:0] INHIBIT_CYCLES = 2'h2;
   // least high or low time of the count input without prescaler
   localparam int CLK_PERIOD_NS = 10;
   localparam int EXT_MIN_LEVEL_NS = 2 * CLK_PERIOD_NS;
   localparam int EXT_MIN_LEVEL_CYC = (EXT_MIN_LEVEL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // ahb transfer type of a new single transfer
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

//--- hw/shared_prescaler.sv
// eight-bit prescaler count, not visible to software
`timescale 1ns/1ps
module shared_prescaler #(
   parameter int WIDTH = 8
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic tick,
   input wire logic clear,
   output logic [WIDTH-1:0] count
);
   // clear takes priority over a tick in the same cycle
   always_ff @(posedge clk) begin
      if (!nrst) begin
         count <= '0;
      end else if (clear) begin
         count <= '0;
      end else if (tick) begin
         count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
      end
   end
endmodule

//--- tb/ext_source.sv
// behavioural count source driving the timer count input
`timescale 1ns/1ps
module ext_source (
   input wire logic clk,
   output logic level
);
   // line rests low until the first burst
   initial begin
      level = 1'b0;
   end
   // toggles the line n times, then holds it still
   // each level held many periods
   task automatic toggle(input int n, input int half);
      for (int i = 0; i < n; i++) begin
         repeat (half) @(posedge clk);
         level <= ~level;
      end
      repeat (2 * half) @(posedge clk);
   endtask
endmodule

//--- tb/timer8_bench.sv
// self-checking bench for the eight-bit timer with shared prescaler
`timescale 1ns/1ps
module timer8_bench
   import tmr_pkg::*;
();
   logic clk, nrst, hsel, hwrite, hreadyout, hresp, ext_in, wdt_tick;
   logic irq, wdt_clear, wdt_postscaled;
   logic [31:0] haddr, hwdata, hrdata, rdat;
   logic [1:0] htrans;
   logic [2:0] hsize;
   int n_fail, compares, cyc, n_post, n_clr;

   // one slave, so its ready is the bus ready
   timer8 timer8_i (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .external_count_input(ext_in), .wdt_tick(wdt_tick), .irq(irq),
      .wdt_clear(wdt_clear), .wdt_postscaled(wdt_postscaled));
   // far side of the count input
   ext_source ext_source_i (.clk(clk), .level(ext_in));

   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // counts watchdog pulses and cuts a hang short
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (wdt_postscaled === 1'b1) n_post <= n_post + 1;
      if (wdt_clear === 1'b1) n_clr <= n_clr + 1;
      if (cyc == 20000) begin
         n_fail = n_fail + 1;
         print_verdict();
      end
   end

   task automatic print_verdict;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic check_eq(input string name, input logic [7:0] exp, input logic [7:0] seen);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // accepts a window where sampling phase leaves a doubt of one to three counts
   task automatic check_range(input string name, input logic [7:0] lo, hi, seen);
      compares++;
      if (!((seen >= lo) === 1'b1 && (seen <= hi) === 1'b1)) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h..%h seen %h", name, lo, hi, seen);
      end
   endtask

   // one single word transfer: address phase until ready, then data phase
   task automatic bus(input logic [3:0] o, input logic w, input logic [7:0] d);
      @(posedge clk);
      haddr <= {28'h0, o};
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      hsize <= 3'h2;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      do @(posedge clk); while (hreadyout !== 1'b1);
      rdat = hrdata;
   endtask

   // watchdog tick pulses, spaced apart
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge clk);
         wdt_tick <= 1'b1;
         @(posedge clk);
         wdt_tick <= 1'b0;
         repeat (2) @(posedge clk);
      end
      repeat (3) @(posedge clk);
   endtask

   // register values after reset
   task automatic t_reset;
      bus(OFF_OPTION, 1'b0, 8'h00);
      check_eq("option", RST_OPTION, rdat[7:0]);
      bus(OFF_COUNTER, 1'b0, 8'h00);
      check_eq("counter", RST_COUNTER, rdat[7:0]);
      bus(OFF_INTCTL, 1'b0, 8'h00);
      check_eq("intctl", 8'h00, rdat[7:0]);
      check_eq("hresp", 8'h00, {7'h0, hresp});
      check_eq("hreadyout", 8'h01, {7'h0, hreadyout});
   endtask

   // timer mode: hold-off after write, wrap, flag and mask
   task automatic t_timer;
      bus(OFF_OPTION, 1'b1, 8'h08);
      bus(OFF_COUNTER, 1'b1, 8'hfe);
      repeat (40) @(posedge clk);
      bus(OFF_COUNTER, 1'b0, 8'h00);
      check_range("counter", 8'h06, 8'h07, rdat[7:0]);
      bus(OFF_INTCTL, 1'b0, 8'h00);
      check_eq("flag", 8'h04, rdat[7:0]);
      check_eq("irq", 8'h00, {7'h0, irq});
      bus(OFF_INTCTL, 1'b1, 8'h24);
      #1 check_eq("irq", 8'h01, {7'h0, irq});
      bus(OFF_INTCTL, 1'b1, 8'h20);
      #1 check_eq("irq", 8'h00, {7'h0, irq});
   endtask

   // sleep freezes the counter
   task automatic t_sleep;
      bus(OFF_CONTROL, 1'b1, 8'h01);
      bus(OFF_CONTROL, 1'b0, 8'h00);
      check_eq("control", 8'h01, rdat[7:0]);
      bus(OFF_COUNTER, 1'b1, 8'h33);
      repeat (40) @(posedge clk);
      bus(OFF_COUNTER, 1'b0, 8'h00);
      check_eq("counter", 8'h33, rdat[7:0]);
      bus(OFF_CONTROL, 1'b1, 8'h00);
   endtask

   // prescaled timer: eight increments per window, rates 0 to 2 and 7
   task automatic t_presc;
      int p;
      int rate;
      for (int r = 0; r < 4; r++) begin
         rate = (r == 3) ? 7 : r;
         bus(OFF_CONTROL, 1'b1, 8'h02);
         bus(OFF_OPTION, 1'b1, 8'(rate));
         bus(OFF_COUNTER, 1'b1, 8'h00);
         repeat (64 << rate) @(posedge clk);
         bus(OFF_COUNTER, 1'b0, 8'h00);
         check_range("counter", 8'h06, 8'h09, rdat[7:0]);
      end
      p = n_post;
      tick(4);
      check_eq("postscaled", 8'h00, 8'(n_post - p));
   endtask

   // watchdog postscale and its clearing
   task automatic t_wdt;
      int p;
      int c;
      // timer to watchdog hand-over, with an intermediate rate
      bus(OFF_CONTROL, 1'b1, 8'h02);
      bus(OFF_COUNTER, 1'b1, 8'h00);
      bus(OFF_OPTION, 1'b1, 8'h0f);
      bus(OFF_CONTROL, 1'b1, 8'h02);
      bus(OFF_OPTION, 1'b1, 8'h09);
      bus(OFF_OPTION, 1'b0, 8'h00);
      check_eq("option", 8'h09, rdat[7:0]);
      c = n_clr;
      bus(OFF_CONTROL, 1'b1, 8'h02);
      p = n_post;
      tick(4);
      check_eq("postscaled", 8'h02, 8'(n_post - p));
      tick(1);
      bus(OFF_CONTROL, 1'b1, 8'h02);
      tick(1);
      check_eq("postscaled", 8'h02, 8'(n_post - p));
      check_eq("wdt clear", 8'h02, 8'(n_clr - c));
   endtask

   // counter mode on both edges, then through the prescaler
   task automatic t_count(input logic [7:0] opt, input int n, input logic [7:0] exp);
      bus(OFF_CONTROL, 1'b1, 8'h02);
      bus(OFF_OPTION, 1'b1, opt);
      bus(OFF_COUNTER, 1'b1, 8'h00);
      repeat (12) @(posedge clk);
      ext_source_i.toggle(n, 6);
      bus(OFF_COUNTER, 1'b0, 8'h00);
      check_eq("counter", exp, rdat[7:0]);
   endtask

   initial begin
      nrst = 1'b0;
      hsel = 1'b1;
      haddr = '0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = '0;
      wdt_tick = 1'b0;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      t_reset();
      t_timer();
      t_sleep();
      t_presc();
      t_wdt();
      t_count(8'h28, 3, 8'h02);
      t_count(8'h38, 3, 8'h02);
      t_count(8'h20, 8, 8'h02);
      print_verdict();
   end
endmodule
